// >>> core/config_fuse_decode_and_verify.v
// configuration fuse store, programming access and option decode
//
// Contract
// - data verify: core instructions fill holding register, shift-out command returns it
// - erased cells and unmapped addresses read as ones
// - unused configuration bits always read zero
// - configuration words readable whatever protection is set
// - eight user identification bytes at fixed range
// - identification word readable under protection; revision top bit in upper byte
// - watchdog forced on by fuse, else software control bit
// - fuse selects master clear reset or digital input on shared pin
// - fuse selects timer oscillator low or high power
// - fuse sets port B analog pins analog or digital after reset
// - fuse routes capture/compare 2 to port C pin 1 or port B pin 3
// - fuse disables debugger freeing port B pins 6 and 7
// - fuse enables extended instructions and indexed addressing
// - two-bit boot block size field decode
// - single-bit boot block size decode
// - boot block size locked once boot or block 0 protected
// - fuse enables low-voltage programming with port B pin 5 entry
// - fuse enables reset on stack overflow or underflow
// - block code-protect bits protect when zero
// - data and boot code-protect bits protect when zero
`timescale 1ns/1ns
`include "cfg_fuse_defines.vh"
module config_fuse_decode_and_verify #(
    // arbitrary identification value
    parameter [15:0] DEVICE_ID = 16'h5a30,
    parameter BOOT_SIZE_BITS = 2
) (
    input wire mclk,
    input wire rstn,
    input wire prog_clk_pin,
    input wire programming_data_pin_in,
    output wire programming_data_pin_out,
    output wire programming_data_pin_oe_n,
    input wire bulk_erase,
    input wire software_watchdog_control_bit,
    input wire master_clear_pin_n,
    input wire stack_fault_event,
    input wire other_protect_active,
    output reg watchdog_run,
    output reg reset_pin_is_master_clear,
    output reg master_clear_reset_req,
    output reg port_e_pin_3_data,
    output reg timer_osc_low_power,
    output reg port_b_analog_default,
    output reg ccp2_on_port_c_pin_1,
    output reg ccp2_on_port_b_pin_3,
    output reg debugger_enable,
    output reg port_b_pin_6_7_gpio,
    output reg extended_instr_enable,
    output reg [12:0] boot_block_words,
    output reg low_voltage_prog_enable,
    output reg port_b_pin_5_is_prog_entry,
    output reg stack_fault_reset_req,
    output reg [5:0] block_code_protect,
    output reg data_code_protect,
    output reg boot_code_protect,
    output reg config_loaded
);
    wire [3:0] cmd;
    wire [15:0] payload;
    wire frame_done;
    wire rd_strobe;
    reg [7:0] tx_byte;
    reg [7:0] rd_byte;
    reg [7:0] cfg_sel;
    reg [21:0] ptr_q;
    reg [7:0] w_q;
    reg [7:0] hold_q;
    reg [7:0] id_mem [0:7];
    reg load_q;
    reg [12:0] bb_words;
    wire [7:0] cfg_rd [0:4];
    wire [7:0] cfg_mask [0:4];
    wire bb_locked;
    wire in_id;
    wire in_cfg;
    wire [21:0] cfg_off;
    wire [2:0] cfg_idx;
    wire wr_frame;
    integer i;

    assign cfg_mask[0] = `MASK_2H;
    assign cfg_mask[1] = `MASK_3H;
    assign cfg_mask[2] = `MASK_4L;
    assign cfg_mask[3] = `MASK_5L;
    assign cfg_mask[4] = `MASK_5H;

    assign in_id = (ptr_q >= `ID_BASE) && (ptr_q <= `ID_LAST);
    assign in_cfg = (ptr_q >= `CFG_BASE) && (ptr_q <= `CFG_LAST);
    assign cfg_off = ptr_q - `CFG_BASE;
    assign cfg_idx = cfg_off[2:0];
    assign wr_frame = frame_done && (cmd == `CMD_TBL_WR);

    assign bb_locked = ~cfg_rd[`CFG_IDX_5L][0] | ~cfg_rd[`CFG_IDX_5H][`BIT_BOOT_PROT] |
                       other_protect_active;

    prog_shift_port u_port (
        .mclk(mclk),
        .rstn(rstn),
        .prog_clk_pin(prog_clk_pin),
        .dat_in(programming_data_pin_in),
        .tx_byte(tx_byte),
        .cmd_q(cmd),
        .payload_q(payload),
        .frame_done_q(frame_done),
        .rd_strobe_q(rd_strobe),
        .dat_out_q(programming_data_pin_out),
        .dat_oe_n_q(programming_data_pin_oe_n)
    );

    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : cfg_cells
            config_byte_cell #(
                .MASK(g == 0 ? `MASK_2H : g == 1 ? `MASK_3H : g == 2 ? `MASK_4L :
                      g == 3 ? `MASK_5L : `MASK_5H)
            ) u_cell (
                .mclk(mclk),
                .erase(bulk_erase),
                .wr_en(wr_frame && in_cfg && (cfg_idx == g)),
                .wr_data(payload[7:0]),
                .lock_mask((g == `CFG_IDX_4L && bb_locked) ? `BB_LOCK_MASK : `NO_LOCK),
                .rd_data(cfg_rd[g])
            );
        end
    endgenerate

    always @* begin
        case (cfg_idx)
            3'h0: cfg_sel = cfg_rd[0] & cfg_mask[0];
            3'h1: cfg_sel = cfg_rd[1] & cfg_mask[1];
            3'h2: cfg_sel = cfg_rd[2] & cfg_mask[2];
            3'h3: cfg_sel = cfg_rd[3] & cfg_mask[3];
            3'h4: cfg_sel = cfg_rd[4] & cfg_mask[4];
            default: cfg_sel = 8'h00;
        endcase
    end

    // read map for table reads
    always @* begin
        if (in_id) begin
            rd_byte = id_mem[ptr_q[2:0]];
        end else if (in_cfg) begin
            rd_byte = cfg_sel;
        end else if (ptr_q == `IDENT_LO) begin
            rd_byte = DEVICE_ID[7:0];
        end else if (ptr_q == `IDENT_HI) begin
            rd_byte = DEVICE_ID[15:8];
        end else begin
            rd_byte = `ERASED_BYTE;
        end
    end

    always @* begin
        if (cmd == `CMD_SHIFT_OUT) begin
            tx_byte = hold_q;
        end else begin
            tx_byte = rd_byte;
        end
    end

    // pointer, working byte and holding register
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ptr_q <= 22'h00_0000;
            w_q <= 8'h00;
            hold_q <= 8'h00;
        end else begin
            if (rd_strobe && (cmd != `CMD_SHIFT_OUT)) begin
                hold_q <= rd_byte;
            end
            if (frame_done && cmd == `CMD_TBL_RD_INC) begin
                ptr_q <= ptr_q + 22'h00_0001;
            end
            if (frame_done && cmd == `CMD_CORE) begin
                if (payload[15:8] == `OP_MOVLW) begin
                    w_q <= payload[7:0];
                end else if (payload[15:8] == `OP_MOVWF) begin
                    case (payload[7:0])
                        `FREG_PTR_U: ptr_q[21:16] <= w_q[5:0];
                        `FREG_PTR_H: ptr_q[15:8] <= w_q;
                        `FREG_PTR_L: ptr_q[7:0] <= w_q;
                        `FREG_HOLD: hold_q <= w_q;
                        default: w_q <= w_q;
                    endcase
                end
            end
        end
    end

    always @(posedge mclk) begin
        if (bulk_erase) begin
            for (i = 0; i < 8; i = i + 1) begin
                id_mem[i] <= `ERASED_BYTE;
            end
        end else if (wr_frame && in_id) begin
            id_mem[ptr_q[2:0]] <= payload[7:0];
        end
    end

    // boot block size decode
    always @* begin
        if (BOOT_SIZE_BITS == 2) begin
            case ({cfg_rd[`CFG_IDX_4L][`BIT_BB_HI], cfg_rd[`CFG_IDX_4L][`BIT_BB_LO]})
                2'b11: bb_words = `BB_4K;
                2'b10: bb_words = `BB_4K;
                2'b01: bb_words = `BB_2K;
                default: bb_words = `BB_1K;
            endcase
        end else begin
            bb_words = cfg_rd[`CFG_IDX_4L][`BIT_BB_LO] ? `BB_2K : `BB_1K;
        end
    end

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            load_q <= 1'b1;
            config_loaded <= 1'b0;
            reset_pin_is_master_clear <= 1'b1;
            timer_osc_low_power <= 1'b1;
            port_b_analog_default <= 1'b1;
            ccp2_on_port_c_pin_1 <= 1'b1;
            ccp2_on_port_b_pin_3 <= 1'b0;
            debugger_enable <= 1'b0;
            port_b_pin_6_7_gpio <= 1'b1;
            extended_instr_enable <= 1'b1;
            boot_block_words <= `BB_4K;
            low_voltage_prog_enable <= 1'b1;
            port_b_pin_5_is_prog_entry <= 1'b1;
            block_code_protect <= 6'h00;
            data_code_protect <= 1'b0;
            boot_code_protect <= 1'b0;
        end else if (load_q) begin
            load_q <= 1'b0;
            config_loaded <= 1'b1;
            reset_pin_is_master_clear <= cfg_rd[`CFG_IDX_3H][`BIT_RST_PIN];
            timer_osc_low_power <= cfg_rd[`CFG_IDX_3H][`BIT_TOSC];
            port_b_analog_default <= cfg_rd[`CFG_IDX_3H][`BIT_PBAD];
            ccp2_on_port_c_pin_1 <= cfg_rd[`CFG_IDX_3H][`BIT_CCP2];
            ccp2_on_port_b_pin_3 <= ~cfg_rd[`CFG_IDX_3H][`BIT_CCP2];
            debugger_enable <= ~cfg_rd[`CFG_IDX_4L][`BIT_DBG];
            port_b_pin_6_7_gpio <= cfg_rd[`CFG_IDX_4L][`BIT_DBG];
            extended_instr_enable <= cfg_rd[`CFG_IDX_4L][`BIT_EXT_SET];
            boot_block_words <= bb_words;
            low_voltage_prog_enable <= cfg_rd[`CFG_IDX_4L][`BIT_LOWV];
            port_b_pin_5_is_prog_entry <= cfg_rd[`CFG_IDX_4L][`BIT_LOWV];
            block_code_protect <= ~cfg_rd[`CFG_IDX_5L][5:0];
            data_code_protect <= ~cfg_rd[`CFG_IDX_5H][`BIT_DATA_PROT];
            boot_code_protect <= ~cfg_rd[`CFG_IDX_5H][`BIT_BOOT_PROT];
        end
    end

    // live controls from held options
    reg wdt_fuse_q;
    reg stv_fuse_q;
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wdt_fuse_q <= 1'b1;
            stv_fuse_q <= 1'b1;
            watchdog_run <= 1'b1;
            master_clear_reset_req <= 1'b0;
            port_e_pin_3_data <= 1'b0;
            stack_fault_reset_req <= 1'b0;
        end else begin
            if (load_q) begin
                wdt_fuse_q <= cfg_rd[`CFG_IDX_2H][`BIT_WDT];
                stv_fuse_q <= cfg_rd[`CFG_IDX_4L][`BIT_STVR];
            end
            watchdog_run <= wdt_fuse_q | software_watchdog_control_bit;
            master_clear_reset_req <= reset_pin_is_master_clear & ~master_clear_pin_n;
            port_e_pin_3_data <= ~reset_pin_is_master_clear & master_clear_pin_n;
            stack_fault_reset_req <= stv_fuse_q & stack_fault_event;
        end
    end
endmodule

// >>> include/cfg_fuse_defines.vh
// constants for the configuration fuse decode and programming port
`ifndef CFG_FUSE_DEFINES_VH
`define CFG_FUSE_DEFINES_VH
`define CMD_CORE 4'h0
`define CMD_SHIFT_OUT 4'h2
`define CMD_TBL_RD 4'h8
`define CMD_TBL_RD_INC 4'h9
`define CMD_TBL_WR 4'hc
`define OP_MOVLW 8'h0e
`define OP_MOVWF 8'h6e
`define FREG_PTR_U 8'hf8
`define FREG_PTR_H 8'hf7
`define FREG_PTR_L 8'hf6
`define FREG_HOLD 8'hf5
`define ID_BASE 22'h20_0000
`define ID_LAST 22'h20_0007
`define CFG_BASE 22'h30_0000
`define CFG_LAST 22'h30_0004
`define CFG_IDX_2H 3'h0
`define CFG_IDX_3H 3'h1
`define CFG_IDX_4L 3'h2
`define CFG_IDX_5L 3'h3
`define CFG_IDX_5H 3'h4
`define IDENT_LO 22'h3f_fffe
`define IDENT_HI 22'h3f_ffff
`define ERASED_BYTE 8'hff
`define MASK_2H 8'h01
`define MASK_3H 8'h87
`define MASK_4L 8'hf5
`define MASK_5L 8'h3f
`define MASK_5H 8'hc0
`define BIT_WDT 0
`define BIT_CCP2 0
`define BIT_TOSC 1
`define BIT_PBAD 2
`define BIT_RST_PIN 7
`define BIT_STVR 0
`define BIT_LOWV 2
`define BIT_BB_LO 4
`define BIT_BB_HI 5
`define BIT_EXT_SET 6
`define BIT_DBG 7
`define BIT_DATA_PROT 6
`define BIT_BOOT_PROT 7
`define BB_LOCK_MASK 8'h30
`define BB_4K 13'h1000
`define BB_2K 13'h0800
`define BB_1K 13'h0400
`define NO_LOCK 8'h00
`define PAY_LAST 4'hf
`define PAY_RD_START 4'h7
`define CMD_LAST 4'h3
`endif

// >>> core/config_byte_cell.v
// one nonvolatile configuration byte with reserved mask and lock mask
`timescale 1ns/1ns
module config_byte_cell #(
    parameter [7:0] MASK = 8'hff
) (
    input wire mclk,
    input wire erase,
    input wire wr_en,
    input wire [7:0] wr_data,
    input wire [7:0] lock_mask,
    output wire [7:0] rd_data
);
    reg [7:0] cell_q;

    // erased cells hold ones, reserved bits stay zero
    always @(posedge mclk) begin
        if (erase) begin
            cell_q <= MASK;
        end else if (wr_en) begin
            cell_q <= ((wr_data & ~lock_mask) | (cell_q & lock_mask)) & MASK;
        end
    end

    assign rd_data = cell_q & MASK;
endmodule

// >>> core/prog_shift_port.v
// serial programming port: 4-bit command, 16-bit payload, byte shift out
`timescale 1ns/1ns
`include "cfg_fuse_defines.vh"
module prog_shift_port (
    input wire mclk,
    input wire rstn,
    input wire prog_clk_pin,
    input wire dat_in,
    input wire [7:0] tx_byte,
    output reg [3:0] cmd_q,
    output reg [15:0] payload_q,
    output reg frame_done_q,
    output reg rd_strobe_q,
    output reg dat_out_q,
    output reg dat_oe_n_q
);
    reg pgc_q;
    reg in_cmd_q;
    reg [3:0] cnt_q;
    reg [7:0] out_sh_q;
    wire fall;
    wire rise;
    wire is_rd;

    assign fall = pgc_q & ~prog_clk_pin;
    assign rise = ~pgc_q & prog_clk_pin;
    assign is_rd = (cmd_q == `CMD_SHIFT_OUT) || (cmd_q == `CMD_TBL_RD) ||
                   (cmd_q == `CMD_TBL_RD_INC);

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pgc_q <= 1'b0;
            in_cmd_q <= 1'b1;
            cnt_q <= 4'h0;
            cmd_q <= 4'h0;
            payload_q <= 16'h0000;
            out_sh_q <= 8'h00;
            frame_done_q <= 1'b0;
            rd_strobe_q <= 1'b0;
            dat_out_q <= 1'b0;
            dat_oe_n_q <= 1'b1;
        end else begin
            pgc_q <= prog_clk_pin;
            frame_done_q <= 1'b0;
            rd_strobe_q <= 1'b0;
            if (fall && in_cmd_q) begin
                cmd_q <= {dat_in, cmd_q[3:1]};
                cnt_q <= (cnt_q == `CMD_LAST) ? 4'h0 : cnt_q + 4'h1;
                in_cmd_q <= (cnt_q != `CMD_LAST);
            end else if (fall) begin
                payload_q <= {dat_in, payload_q[15:1]};
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q == `PAY_RD_START && is_rd) begin
                    out_sh_q <= tx_byte;
                    rd_strobe_q <= 1'b1;
                    dat_oe_n_q <= 1'b0;
                end
                if (cnt_q == `PAY_LAST) begin
                    in_cmd_q <= 1'b1;
                    frame_done_q <= 1'b1;
                    dat_oe_n_q <= 1'b1;
                end
            end else if (rise && !in_cmd_q && !dat_oe_n_q) begin
                dat_out_q <= out_sh_q[0];
                out_sh_q <= {1'b0, out_sh_q[7:1]};
            end
        end
    end
endmodule

// >>> testbench/prog_model.sv
// programmer model on the serial programming port
`timescale 1ns/1ns
module prog_model (
    input wire mclk,
    input wire dout,
    input wire oe_n,
    output logic pclk,
    output wire pdat
);
    logic drv = 1'h1;
    logic val = 1'h0;
    logic last = 1'h0;
    initial pclk = 1'h0;
    // released line toggles every cycle
    assign pdat = !oe_n ? dout : (drv ? val : ~last);
    always @(posedge mclk) last <= pdat;
    // command and payload lsb first, read byte taken while clock high
    task automatic frame(input logic [3:0] c, input logic [15:0] p, output logic [7:0] rd);
        for (int i = 0; i < 20; i++) begin
            drv <= i < 12 || !(c == 4'h2 || c[3:1] == 3'h4);
            val <= i < 4 ? c[i] : p[i - 4];
            pclk <= 1'h1;
            repeat (3) @(posedge mclk);
            if (i >= 12) rd[i - 12] = pdat;
            pclk <= 1'h0;
            repeat (3) @(posedge mclk);
        end
    endtask
endmodule

// >>> testbench/fuse_monitor.sv
// assertions on the configuration fuse block ports
`timescale 1ns/1ns
module fuse_monitor (
    input wire mclk,
    input wire rstn,
    input wire programming_data_pin_oe_n,
    input wire software_watchdog_control_bit,
    input wire master_clear_pin_n,
    input wire stack_fault_event,
    input wire watchdog_run,
    input wire reset_pin_is_master_clear,
    input wire master_clear_reset_req,
    input wire port_e_pin_3_data,
    input wire ccp2_on_port_c_pin_1,
    input wire ccp2_on_port_b_pin_3,
    input wire debugger_enable,
    input wire port_b_pin_6_7_gpio,
    input wire extended_instr_enable,
    input wire [12:0] boot_block_words,
    input wire stack_fault_reset_req,
    input wire [5:0] block_code_protect,
    input wire config_loaded
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    sequence s_live;
        config_loaded && $past(config_loaded);
    endsequence
    sequence s_drive;
        !programming_data_pin_oe_n [*8] ##[1:1000] programming_data_pin_oe_n;
    endsequence
    chk_wdt_sw_on: assert property (
        s_live ##0 software_watchdog_control_bit |=> watchdog_run) else $error("watchdog off");
    chk_master_clear_input_request: assert property (
        s_live ##0 (reset_pin_is_master_clear && !master_clear_pin_n) |=> master_clear_reset_req)
        else $error("master clear request missing");
    chk_pin_as_input: assert property (
        s_live ##0 !reset_pin_is_master_clear |=> port_e_pin_3_data == $past(master_clear_pin_n))
        else $error("input pin data wrong");
    chk_stack_request: assert property (
        stack_fault_reset_req |-> $past(stack_fault_event)) else $error("stack reset uncaused");
    chk_ccp2_one_route: assert property (
        ccp2_on_port_c_pin_1 != ccp2_on_port_b_pin_3) else $error("ccp2 route wrong");
    chk_debug_pins: assert property (
        debugger_enable != port_b_pin_6_7_gpio) else $error("debug pins wrong");
    chk_boot_size_legal: assert property (
        boot_block_words inside {13'h1000, 13'h0800, 13'h0400}) else $error("boot size illegal");
    chk_options_held: assert property (
        s_live |-> $stable({boot_block_words, block_code_protect, extended_instr_enable}))
        else $error("options changed");
    chk_data_drive: assert property (
        $fell(programming_data_pin_oe_n) |-> s_drive) else $error("data drive length wrong");
endmodule
bind config_fuse_decode_and_verify fuse_monitor fuse_mon (.*);

// >>> testbench/testbench.sv
// bench for the configuration fuse block
`timescale 1ns/1ns
module testbench;
    // arbitrary identification value
    localparam logic [15:0] DEV_ID = 16'h3ca5;
    logic mclk = 1'h0;
    logic rstn = 1'h0;
    logic erase = 1'h0;
    logic sw = 1'h0;
    logic mpin = 1'h1;
    logic stk = 1'h0;
    logic oth = 1'h0;
    logic [7:0] r;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    wire pclk, pdat, dout, oe_n, wdt, mce, mcr, pe3, tlp, pba, cc1, cb3, dbg, g67, xin;
    wire lv_en, entry_pin, sfr, dcp, bkp, ld;
    wire [12:0] bbw;
    wire [12:0] bbw1;
    wire [5:0] bcp;
    wire [11:0] opt = {mce, tlp, pba, cc1, cb3, dbg, g67, xin, lv_en, entry_pin, dcp, bkp};
    logic [7:0] msk [5] = '{8'h01, 8'h87, 8'hf5, 8'h3f, 8'hc0};
    always #5 mclk = ~mclk;
    prog_model prog (.mclk(mclk), .dout(dout), .oe_n(oe_n), .pclk(pclk), .pdat(pdat));
    config_fuse_decode_and_verify #(.DEVICE_ID(DEV_ID)) dut (
        .mclk(mclk), .rstn(rstn), .prog_clk_pin(pclk), .programming_data_pin_in(pdat),
        .programming_data_pin_out(dout), .programming_data_pin_oe_n(oe_n),
        .bulk_erase(erase), .software_watchdog_control_bit(sw), .master_clear_pin_n(mpin),
        .stack_fault_event(stk), .other_protect_active(oth), .watchdog_run(wdt),
        .reset_pin_is_master_clear(mce), .master_clear_reset_req(mcr),
        .port_e_pin_3_data(pe3), .timer_osc_low_power(tlp), .port_b_analog_default(pba),
        .ccp2_on_port_c_pin_1(cc1), .ccp2_on_port_b_pin_3(cb3), .debugger_enable(dbg),
        .port_b_pin_6_7_gpio(g67), .extended_instr_enable(xin), .boot_block_words(bbw),
        .low_voltage_prog_enable(lv_en), .port_b_pin_5_is_prog_entry(entry_pin),
        .stack_fault_reset_req(sfr), .block_code_protect(bcp), .data_code_protect(dcp),
        .boot_code_protect(bkp), .config_loaded(ld));
    config_fuse_decode_and_verify #(.DEVICE_ID(DEV_ID), .BOOT_SIZE_BITS(1)) dut_one_bit (
        .mclk(mclk), .rstn(rstn), .prog_clk_pin(pclk), .programming_data_pin_in(pdat),
        .programming_data_pin_out(), .programming_data_pin_oe_n(), .bulk_erase(erase),
        .software_watchdog_control_bit(sw), .master_clear_pin_n(mpin),
        .stack_fault_event(stk), .other_protect_active(oth), .watchdog_run(),
        .reset_pin_is_master_clear(), .master_clear_reset_req(), .port_e_pin_3_data(),
        .timer_osc_low_power(), .port_b_analog_default(), .ccp2_on_port_c_pin_1(),
        .ccp2_on_port_b_pin_3(), .debugger_enable(), .port_b_pin_6_7_gpio(),
        .extended_instr_enable(), .boot_block_words(bbw1), .low_voltage_prog_enable(),
        .port_b_pin_5_is_prog_entry(), .stack_fault_reset_req(), .block_code_protect(),
        .data_code_protect(), .boot_code_protect(), .config_loaded());
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // pointer set by core frames, then one table command
    task automatic acc(input logic [21:0] a, input logic [3:0] c, input logic [7:0] b);
        logic [7:0] f [3] = '{8'hf8, 8'hf7, 8'hf6};
        logic [23:0] w;
        w = {2'h0, a};
        for (int j = 0; j < 3; j++) begin
            prog.frame(4'h0, {8'h0e, w[23 - 8 * j -: 8]}, r);
            prog.frame(4'h0, {8'h6e, f[j]}, r);
        end
        prog.frame(c, {8'h00, b}, r);
    endtask
    task automatic boot(input logic e);
        @(posedge mclk);
        erase <= e;
        rstn <= 1'h0;
        repeat (12) @(posedge mclk);
        erase <= 1'h0;
        rstn <= 1'h1;
        repeat (3) @(posedge mclk);
    endtask
    task automatic live(input logic s, input logic m, input logic k, input logic [3:0] e);
        @(posedge mclk);
        sw <= s;
        mpin <= m;
        stk <= k;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk("live outputs", {12'h000, e}, {12'h000, wdt, mcr, pe3, sfr});
        @(posedge mclk);
        stk <= 1'h0;
        mpin <= 1'h1;
    endtask
    task automatic t_blank;
        boot(1'h1);
        chk("loaded", 16'h0001, {15'h0000, ld});
        chk("options", 16'h0f3c, {4'h0, opt});
        chk("boot size", 16'h1000, {3'h0, bbw});
        chk("block protect", 16'h0000, {10'h000, bcp});
        live(1'h0, 1'h0, 1'h1, 4'hd);
        for (int i = 0; i < 5; i++) begin
            acc(22'h30_0000 + 22'(i), 4'h8, 8'h00);
            chk("config", {8'h00, msk[i]}, {8'h00, r});
        end
        // ID bytes and code space read erased
        for (int i = 0; i < 9; i++) begin
            acc(i < 8 ? 22'h20_0000 + 22'(i) : 22'h00_0000, 4'h8, 8'h00);
            chk("blank", 16'h00ff, {8'h00, r});
        end
        $display("test blank done");
    endtask
    task automatic t_ident;
        prog.frame(4'h0, 16'h0ea5, r);
        prog.frame(4'h0, 16'h6ef5, r);
        prog.frame(4'h2, 16'h0000, r);
        chk("holding", 16'h00a5, {8'h00, r});
        acc(22'h3f_fffe, 4'h9, 8'h00);
        chk("id low", {8'h00, DEV_ID[7:0]}, {8'h00, r});
        prog.frame(4'h8, 16'h0000, r);
        chk("id high", {8'h00, DEV_ID[15:8]}, {8'h00, r});
        chk("revision bit", {15'h0000, DEV_ID[12]}, {15'h0000, r[4]});
        $display("test ident done");
    endtask
    task automatic t_boot_size;
        logic [12:0] e [4] = '{13'h1000, 13'h1000, 13'h0800, 13'h0400};
        logic [12:0] e1 [4] = '{13'h0800, 13'h0400, 13'h0800, 13'h0400};
        for (int k = 0; k < 4; k++) begin
            boot(1'h1);
            acc(22'h30_0002, 4'hc, {2'h3, 2'(3 - k), 4'h5});
            boot(1'h0);
            chk("boot size", {3'h0, e[k]}, {3'h0, bbw});
            chk("one bit size", {3'h0, e1[k]}, {3'h0, bbw1});
        end
        oth <= 1'h1;
        acc(22'h30_0002, 4'hc, 8'hd5);
        acc(22'h30_0002, 4'h8, 8'h00);
        chk("size lock", 16'h00c5, {8'h00, r});
        oth <= 1'h0;
        $display("test boot size done");
    endtask
    task automatic t_program;
        logic [7:0] v [5] = '{8'h00, 8'h00, 8'h10, 8'h2a, 8'h40};
        boot(1'h1);
        for (int i = 0; i < 8; i++) acc(22'h20_0000 + 22'(i), 4'hc, 8'hf0 | 8'(i));
        // configuration written after the other areas
        for (int i = 0; i < 5; i++) acc(22'h30_0000 + 22'(i), 4'hc, v[i] | ~msk[i]);
        chk("options held", 16'h0f3c, {4'h0, opt});
        acc(22'h30_0002, 4'hc, 8'h00);
        boot(1'h0);
        chk("options", 16'h00c1, {4'h0, opt});
        chk("boot size", 16'h0800, {3'h0, bbw});
        chk("block protect", 16'h0015, {10'h000, bcp});
        live(1'h0, 1'h0, 1'h1, 4'h0);
        live(1'h1, 1'h1, 1'h0, 4'ha);
        for (int i = 0; i < 13; i++) begin
            acc(i < 5 ? 22'h30_0000 + 22'(i) : 22'h20_0000 + 22'(i - 5), 4'h8, 8'h00);
            chk("readback", {8'h00, i < 5 ? v[i] : 8'hf0 | 8'(i - 5)}, {8'h00, r});
        end
        t_ident();
        $display("test program done");
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 70000) begin
            error_cnt++;
            test_done();
        end
    end
    initial begin
        t_blank();
        t_ident();
        t_boot_size();
        t_program();
        test_done();
    end
endmodule
